/* hw/rtc_defines.vh */
// constants for the serial calendar clock
`ifndef RTC_DEFINES_VH
`define RTC_DEFINES_VH
`define RTC_DEV_ADDR      7'h68
`define RTC_MEM_DEPTH     64
`define RTC_REG_SEC       6'h00
`define RTC_REG_MIN       6'h01
`define RTC_REG_HOUR      6'h02
`define RTC_REG_WDAY      6'h03
`define RTC_REG_MDAY      6'h04
`define RTC_REG_MON       6'h05
`define RTC_REG_YEAR      6'h06
`define RTC_REG_CTRL      6'h07
`define RTC_BIT_HALT      7
`define RTC_BIT_CEN_EN    7
`define RTC_BIT_CEN_FLAG  6
`define RTC_BIT_OUT       7
`define RTC_BIT_FT        6
`define RTC_BIT_SIGN      5
`define RTC_CTRL_RESET    8'h80
`define RTC_TICK_HZ       32768
`define RTC_CLK_HZ        20000000
`define RTC_FREEZE_MS     250
`define RTC_FREEZE_CYC    ((`RTC_CLK_HZ / 1000) * `RTC_FREEZE_MS)
`define RTC_SEC_TICKS     32768
`define RTC_SHORT_TICKS   128
`define RTC_LONG_TICKS    256
`define RTC_CAL_MINUTES   64
`endif

/* hw/rtc_serial_clock.v */
// serial calendar clock with calibration and test output
`include "rtc_defines.vh"
`timescale 1ns/100ps
`default_nettype none
module rtc_serial_clock #(
  parameter FREEZE_CYC = `RTC_FREEZE_CYC
) (
  input  wire clock,
  input  wire rst_n,
  input  wire osc_in,
  input  wire supply_ok,
  input  wire scl_in,
  input  wire sda_in,
  output reg  sda_out,
  output reg  sda_oe,
  output reg  test_output_pin_out,
  output reg  test_output_pin_oe
);
  localparam S_IDLE = 5'b00001;
  localparam S_RECV = 5'b00010;
  localparam S_RACK = 5'b00100;
  localparam S_SEND = 5'b01000;
  localparam S_SACK = 5'b10000;
  // freeze timer reload, cut to the counter width
  localparam [31:0] FREEZE_LOAD = FREEZE_CYC;

  // synchronisers
  reg [2:0] scl_s;
  reg [2:0] sda_s;
  reg [2:0] osc_s;
  reg [1:0] pwr_s;
  always @(posedge clock) begin
    scl_s <= {scl_s[1:0], scl_in};
    sda_s <= {sda_s[1:0], sda_in};
    osc_s <= {osc_s[1:0], osc_in};
    pwr_s <= {pwr_s[0], supply_ok};
  end
  wire scl_rise  = scl_s[1] & ~scl_s[2];
  wire scl_fall  = ~scl_s[1] & scl_s[2];
  wire start_det = scl_s[1] & scl_s[2] & ~sda_s[1] & sda_s[2];
  wire stop_det  = scl_s[1] & scl_s[2] & sda_s[1] & ~sda_s[2];
  wire osc_tick  = osc_s[1] & ~osc_s[2];
  wire pwr_ok    = pwr_s[1];

  // memory and live time
  reg [7:0] mem [0:`RTC_MEM_DEPTH-1];
  reg [7:0] t_sec, t_min, t_hour, t_wday, t_mday, t_mon, t_year;
  reg [7:0] ctrl;
  reg [5:0] ptr;
  reg [4:0] state;
  reg [3:0] bitn;
  reg [7:0] shreg;
  reg       rd_mode;
  reg       first_byte;
  reg       addr_phase;
  reg       ack_ok;
  reg [22:0] freeze_cnt;
  reg        reading_clock;

  wire [5:0] ptr_inc = ptr + 6'h01;
  // holding-register readback from mem, control from ctrl
  wire [7:0] rd_byte = (ptr == `RTC_REG_CTRL) ? ctrl : mem[ptr];
  wire       osc_halt_bit = t_sec[`RTC_BIT_HALT];

  // serial slave
  reg        wr_en;
  reg [5:0]  wr_addr;
  reg [7:0]  wr_data;

  always @(posedge clock) begin
    wr_en <= 1'b0;
    if (!rst_n || !pwr_ok) begin
      // deselect drops the transfer and lets go of the bus
      state    <= S_IDLE;
      sda_out  <= 1'b0;
      sda_oe   <= 1'b0;
      bitn     <= 4'h0;
      shreg    <= 8'h00;
      rd_mode  <= 1'b0;
      first_byte <= 1'b0;
      addr_phase <= 1'b0;
      ack_ok   <= 1'b0;
      wr_addr  <= 6'h00;
      wr_data  <= 8'h00;
      if (!pwr_ok)
        ptr <= 6'h00;
      if (!rst_n)
        ptr <= 6'h00;
    end else if (start_det) begin
      // a repeated start drops any byte in progress
      state      <= S_RECV;
      bitn       <= 4'h0;
      addr_phase <= 1'b1;
      sda_oe     <= 1'b0;
    end else if (stop_det) begin
      state  <= S_IDLE;
      sda_oe <= 1'b0;
    end else begin
      case (state)
        S_IDLE: begin
          sda_oe <= 1'b0;
        end
        S_RECV: begin
          if (scl_rise) begin
            shreg <= {shreg[6:0], sda_s[1]};
            bitn  <= bitn + 4'h1;
          end else if (scl_fall && bitn == 4'h8) begin
            bitn <= 4'h0;
            if (addr_phase) begin
              if (shreg[7:1] == `RTC_DEV_ADDR) begin
                sda_oe     <= 1'b1;
                rd_mode    <= shreg[0];
                first_byte <= ~shreg[0];
                addr_phase <= 1'b0;
                state      <= S_RACK;
              end else
                state <= S_IDLE;
            end else begin
              sda_oe <= 1'b1;
              state  <= S_RACK;
              if (first_byte) begin
                ptr        <= shreg[5:0];
                first_byte <= 1'b0;
              end else begin
                wr_en   <= 1'b1;
                wr_addr <= ptr;
                wr_data <= shreg;
                ptr     <= ptr_inc;
              end
            end
          end
        end
        S_RACK: begin
          // first data bit goes out on the fall that ends the ack
          if (scl_fall) begin
            if (rd_mode) begin
              shreg   <= rd_byte;
              sda_oe  <= ~rd_byte[7];
              bitn    <= 4'h1;
              state   <= S_SEND;
            end else begin
              sda_oe <= 1'b0;
              state  <= S_RECV;
            end
          end
        end
        S_SEND: begin
          if (scl_fall) begin
            if (bitn == 4'h8) begin
              // line freed for the master's ack bit
              sda_oe <= 1'b0;
              state  <= S_SACK;
            end else begin
              sda_oe <= ~shreg[3'h7 - bitn[2:0]];
              bitn   <= bitn + 4'h1;
            end
          end
        end
        S_SACK: begin
          // ack taken while clock high, acted on at the fall
          if (scl_rise)
            ack_ok <= ~sda_s[1];
          else if (scl_fall) begin
            if (ack_ok) begin
              ptr     <= ptr_inc;
              shreg   <= (ptr_inc == `RTC_REG_CTRL) ? ctrl : mem[ptr_inc];
              sda_oe  <= ~((ptr_inc == `RTC_REG_CTRL) ? ctrl[7] : mem[ptr_inc][7]);
              bitn    <= 4'h1;
              state   <= S_SEND;
            end else begin
              sda_oe <= 1'b0;
              state  <= S_IDLE;
            end
          end
        end
        default: state <= S_IDLE;
      endcase
    end
  end

  // freeze of holding registers while clock locations are read
  // timer restarts on every such read; live time keeps counting
  always @(posedge clock) begin
    if (!rst_n) begin
      reading_clock <= 1'b0;
      freeze_cnt    <= 23'h000000;
    end else begin
      reading_clock <= rd_mode && (state != S_IDLE) && (ptr < `RTC_REG_CTRL);
      if (reading_clock)
        freeze_cnt <= FREEZE_LOAD[22:0];
      else if (freeze_cnt != 23'h000000)
        freeze_cnt <= freeze_cnt - 23'h000001;
    end
  end
  wire frozen = reading_clock || (freeze_cnt != 23'h000000);

  // divider, calibration and calendar
  // last divider count of a nominal, shortened and lengthened second
  localparam [31:0] SEC_LAST   = `RTC_SEC_TICKS - 1;
  localparam [31:0] SHORT_LAST = `RTC_SEC_TICKS - `RTC_SHORT_TICKS - 1;
  localparam [31:0] LONG_LAST  = `RTC_SEC_TICKS + `RTC_LONG_TICKS - 1;
  localparam [31:0] CAL_LAST   = `RTC_CAL_MINUTES - 1;

  reg [15:0] div;
  reg [5:0]  cal_min;
  reg        cal_this_min;
  reg        cal_done;
  reg [8:0]  half512;
  wire [4:0] cal_mag  = ctrl[4:0];
  wire       cal_pos  = ctrl[`RTC_BIT_SIGN];
  wire       cal_act  = (cal_min < {cal_mag, 1'b0}) && cal_this_min && !cal_done;
  wire [15:0] sec_end = !cal_act ? SEC_LAST[15:0] :
                        cal_pos ? SHORT_LAST[15:0] : LONG_LAST[15:0];
  wire sec_tick = osc_tick && !osc_halt_bit && (div == sec_end);

  function [7:0] bcd_inc;
    input [7:0] v;
    begin
      bcd_inc = (v[3:0] == 4'h9) ? {v[7:4] + 4'h1, 4'h0} : {v[7:4], v[3:0] + 4'h1};
    end
  endfunction

  // leap year: bcd year divisible by four
  wire [7:0] yr = t_year;
  wire leap = ((yr[4] == 1'b0) && (yr[1:0] == 2'b00)) || ((yr[4] == 1'b1) && (yr[1:0] == 2'b10));
  reg [7:0] mlen;
  always @* begin
    case (t_mon[4:0])
      5'h02:   mlen = leap ? 8'h29 : 8'h28;
      5'h04, 5'h06, 5'h09, 5'h11: mlen = 8'h30;
      default: mlen = 8'h31;
    endcase
  end

  wire host_wr = wr_en && (wr_addr <= `RTC_REG_YEAR);

  // next bcd values of the live time fields
  wire [7:0] sec_inc  = bcd_inc({1'b0, t_sec[6:0]});
  wire [7:0] min_inc  = bcd_inc({1'b0, t_min[6:0]});
  wire [7:0] hour_inc = bcd_inc({2'b00, t_hour[5:0]});
  wire [7:0] mday_inc = bcd_inc({2'b00, t_mday[5:0]});
  wire [7:0] mon_inc  = bcd_inc({3'b000, t_mon[4:0]});
  wire [7:0] year_inc = bcd_inc(t_year);

  always @(posedge clock) begin
    if (!rst_n) begin
      ctrl    <= `RTC_CTRL_RESET;
      div     <= 16'h0000;
      cal_min <= 6'h00;
      cal_this_min <= 1'b0;
      cal_done <= 1'b0;
      half512 <= 9'h000;
      test_output_pin_out <= 1'b0;
      test_output_pin_oe  <= 1'b0;
    end else begin
      if (wr_en && wr_addr == `RTC_REG_CTRL)
        ctrl <= wr_data;
      // halt stops both the divider and the test frequency
      if (osc_tick && !osc_halt_bit) begin
        div     <= sec_tick ? 16'h0000 : div + 16'h0001;
        half512 <= half512 + 9'h001;
      end
      if (sec_tick) begin
        if (cal_act)
          cal_done <= 1'b1;
        cal_this_min <= 1'b1;
        if (t_sec[6:0] == 7'h59) begin
          cal_done <= 1'b0;
          cal_min  <= (cal_min == CAL_LAST[5:0]) ? 6'h00 : cal_min + 6'h01;
        end
      end
      // open drain: only the enable moves, the level stays low
      test_output_pin_out <= 1'b0;
      if (ctrl[`RTC_BIT_FT])
        test_output_pin_oe <= !osc_halt_bit && half512[5];
      else
        test_output_pin_oe <= ~ctrl[`RTC_BIT_OUT];
    end
  end

  // a host write wins over a tick in the same cycle
  always @(posedge clock) begin
    if (host_wr) begin
      case (wr_addr)
        `RTC_REG_SEC:  t_sec  <= wr_data;
        `RTC_REG_MIN:  t_min  <= wr_data;
        `RTC_REG_HOUR: t_hour <= wr_data;
        `RTC_REG_WDAY: t_wday <= wr_data;
        `RTC_REG_MDAY: t_mday <= wr_data;
        `RTC_REG_MON:  t_mon  <= wr_data;
        default:       t_year <= wr_data;
      endcase
    end else if (sec_tick) begin
      if (t_sec[6:0] != 7'h59)
        t_sec[6:0] <= sec_inc[6:0];
      else begin
        t_sec[6:0] <= 7'h00;
        if (t_min[6:0] != 7'h59)
          t_min <= min_inc;
        else begin
          t_min <= 8'h00;
          if (t_hour[5:0] != 6'h23)
            t_hour[5:0] <= hour_inc[5:0];
          else begin
            t_hour[5:0] <= 6'h00;
            t_wday <= (t_wday[2:0] == 3'h7) ? 8'h01 : {5'h00, t_wday[2:0] + 3'h1};
            if (t_mday[5:0] != mlen[5:0])
              t_mday <= mday_inc;
            else begin
              t_mday <= 8'h01;
              if (t_mon[4:0] != 5'h12)
                t_mon <= mon_inc;
              else begin
                t_mon <= 8'h01;
                t_year <= (t_year == 8'h99) ? 8'h00 : year_inc;
                if (t_year == 8'h99 && t_hour[`RTC_BIT_CEN_EN])
                  t_hour[`RTC_BIT_CEN_FLAG] <= ~t_hour[`RTC_BIT_CEN_FLAG];
              end
            end
          end
        end
      end
    end
  end

  // byte store, holding copy refreshed unless frozen
  genvar gi;
  generate
    for (gi = 0; gi < `RTC_MEM_DEPTH; gi = gi + 1) begin : g_mem
      always @(posedge clock) begin
        if (wr_en && wr_addr == gi)
          mem[gi] <= wr_data;
        else if (gi < 7 && !frozen) begin
          case (gi)
            0:       mem[gi] <= t_sec;
            1:       mem[gi] <= t_min;
            2:       mem[gi] <= t_hour;
            3:       mem[gi] <= t_wday;
            4:       mem[gi] <= t_mday;
            5:       mem[gi] <= t_mon;
            default: mem[gi] <= t_year;
          endcase
        end
      end
    end
  endgenerate
endmodule // rtc_serial_clock
`default_nettype wire

/* testbench/rtc_serial_clock_sva.sv */
// port assertions for the serial calendar clock
`timescale 1ns/100ps
`default_nettype none
module rtc_chk (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic osc_in,
  input wire logic supply_ok,
  input wire logic scl_in,
  input wire logic sda_in,
  input wire logic sda_out,
  input wire logic sda_oe,
  input wire logic test_output_pin_out,
  input wire logic test_output_pin_oe
);
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);
  a_sda_open_drain: assert property (!sda_out)
    else $error("sda_out high");
  a_pin_open_drain: assert property (!test_output_pin_out)
    else $error("pin out high");
  a_deselect_frees_bus: assert property (!supply_ok [*4] |-> !sda_oe)
    else $error("bus held while deselected");
  a_ack_stands_high: assert property (disable iff (!rst_n || !supply_ok) scl_in [*4] |-> $stable(sda_oe))
    else $error("sda moved while scl high");
  a_drive_in_low: assert property (disable iff (!rst_n || !supply_ok) $changed(sda_oe) |-> !scl_in)
    else $error("sda changed with scl high");
  a_reset_bus_free: assert property ($rose(rst_n) |-> !sda_oe)
    else $error("sda held after reset");
  a_reset_pin_free: assert property ($rose(rst_n) |-> ##1 !test_output_pin_oe)
    else $error("pin low after reset");
  a_pin_on_osc: assert property (($stable(osc_in) && scl_in) [*8] |-> $stable(test_output_pin_oe))
    else $error("pin moved without osc edge");
endmodule // rtc_chk
bind rtc_serial_clock rtc_chk u_chk (.clock(clock), .rst_n(rst_n), .osc_in(osc_in), .supply_ok(supply_ok),
  .scl_in(scl_in), .sda_in(sda_in), .sda_out(sda_out), .sda_oe(sda_oe),
  .test_output_pin_out(test_output_pin_out), .test_output_pin_oe(test_output_pin_oe));
`default_nettype wire

/* testbench/rtc_bus_master.sv */
// two-wire bus master model for the serial calendar clock
`timescale 1ns/100ps
`default_nettype none
module rtc_bus_master #(
  parameter HALF = 4
) (
  input  wire logic clock,
  input  wire logic sda_line,
  output var  logic scl,
  output var  logic sda_low
);
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
  end
  task automatic hold(input int k);
    repeat (k) @(negedge clock);
  endtask
  // start is cond(1,0), stop is cond(0,1)
  task automatic cond(input logic s0, input logic s1);
    scl = 1'b0;
    hold(1);
    sda_low = !s0;
    hold(HALF);
    scl = 1'b1;
    hold(HALF);
    sda_low = !s1;
    hold(HALF);
  endtask
  task automatic bit_x(input logic v, output logic r);
    scl = 1'b0;
    hold(1);
    sda_low = !v;
    hold(HALF - 1);
    scl = 1'b1;
    hold(HALF / 2);
    r = sda_line;
    hold(HALF - HALF / 2);
  endtask
  // ninth bit pulled low when mack set
  task automatic xfer(input logic [7:0] v, input logic mack, output logic [7:0] q, output logic sack);
    logic r;
    for (int i = 7; i >= 0; i--) bit_x(v[i], q[i]);
    bit_x(!mack, r);
    sack = !r;
  endtask
endmodule // rtc_bus_master
`default_nettype wire

/* testbench/rtc_serial_clock_tb_top.sv */
// self-checking bench for the serial calendar clock
`include "rtc_defines.vh"
`timescale 1ns/100ps
`default_nettype none
module rtc_serial_clock_tb_top;
  localparam logic [7:0] DW = {`RTC_DEV_ADDR, 1'b0};
  logic       clock;
  logic       rst_n;
  logic       osc_in;
  logic       supply_ok;
  logic       sda_oe;
  logic       pin_oe;
  logic       m_scl;
  logic       m_low;
  logic       sda_line;
  logic       a;
  logic [7:0] b;
  logic [7:0] d[$];
  logic [7:0] q[$];
  logic [7:0] ctl[4] = '{8'h00, 8'h80, 8'h40, 8'h7F};
  int         seed;
  int         n;
  int         n_mismatch = 0;
  int         checks = 0;
  assign sda_line = !(m_low || sda_oe);
  rtc_serial_clock #(.FREEZE_CYC(50)) dut (.clock(clock), .rst_n(rst_n), .osc_in(osc_in), .supply_ok(supply_ok),
    .scl_in(m_scl), .sda_in(sda_line), .sda_out(), .sda_oe(sda_oe), .test_output_pin_out(),
    .test_output_pin_oe(pin_oe));
  rtc_bus_master #(.HALF(4)) m (.clock(clock), .sda_line(sda_line), .scl(m_scl), .sda_low(m_low));
  initial begin
    clock = 1'b0;
    forever #25 clock = ~clock;
  end
  initial begin
    osc_in = 1'b0;
    forever begin
      repeat (10) @(negedge clock);
      osc_in = ~osc_in;
    end
  end
  initial begin
    repeat (40000) @(posedge clock);
    n_mismatch++;
    stop_test();
  end
  function automatic logic [7:0] bcd(input int v);
    return {4'(v / 10), 4'(v % 10)};
  endfunction
  task automatic chk(input string s, input logic [7:0] e, input logic [7:0] g);
    checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("Error %s expected %h seen %h", s, e, g);
    end
  endtask
  task automatic stop_test();
    $display("checks %0d n_mismatch %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  task automatic wr(input logic [7:0] ad, input logic [7:0] p, input logic [7:0] w[$], input logic e);
    m.cond(1'b1, 1'b0);
    m.xfer(ad, 1'b0, b, a);
    chk("ack_addr", {7'h00, e}, {7'h00, a});
    m.xfer(p, 1'b0, b, a);
    chk("ack_ptr", {7'h00, e}, {7'h00, a});
    foreach (w[i]) begin
      m.xfer(w[i], 1'b0, b, a);
      chk("ack_data", {7'h00, e}, {7'h00, a});
    end
    m.cond(1'b0, 1'b1);
  endtask
  task automatic rd(input logic setp, input logic [7:0] p, input int k);
    q = {};
    if (setp) begin
      m.cond(1'b1, 1'b0);
      m.xfer(DW, 1'b0, b, a);
      m.xfer(p, 1'b0, b, a);
    end
    m.cond(1'b1, 1'b0);
    m.xfer(DW | 8'h01, 1'b0, b, a);
    chk("ack_read", 8'h01, {7'h00, a});
    for (int i = 0; i < k; i++) begin
      m.xfer(8'hFF, i < k - 1, b, a);
      q.push_back(b);
    end
    m.cond(1'b0, 1'b1);
  endtask
  // osc rises between two toggles of the test pin
  task automatic pin_period();
    logic p;
    logic o;
    p = pin_oe;
    repeat (3000) if (pin_oe === p) @(posedge clock);
    p = pin_oe;
    o = osc_in;
    n = 0;
    repeat (3000) if (pin_oe === p) begin
      @(posedge clock);
      if (osc_in && !o) n++;
      o = osc_in;
    end
  endtask
  initial begin
    seed = 84028;
    rst_n = 1'b0;
    supply_ok = 1'b1;
    repeat (4) @(negedge clock);
    rst_n = 1'b1;
    repeat (4) @(negedge clock);
    chk("pin_reset", 8'h00, {7'h00, pin_oe});
    wr(DW, 8'h00, {8'h80}, 1'b1);
    wr(DW, 8'h00, {8'h00}, 1'b1);
    // top ram byte, then halted seconds and minutes after the wrap
    d = {8'($random(seed)), 8'h80 | bcd({$random(seed)} % 60), bcd({$random(seed)} % 60)};
    wr(DW, 8'h3F, d, 1'b1);
    rd(1'b1, 8'h3F, 3);
    foreach (d[i]) chk("seq_read", d[i], q[i]);
    rd(1'b0, 8'h00, 1);
    chk("cur_read", d[2], q[0]);
    wr(8'hD2, 8'h08, {8'h11}, 1'b0);
    // oscillator must run for the test frequency
    d[1][7] = 1'b0;
    wr(DW, 8'h00, {d[1]}, 1'b1);
    foreach (ctl[i]) begin
      wr(DW, 8'h07, {ctl[i]}, 1'b1);
      rd(1'b1, 8'h07, 1);
      chk("ctrl", ctl[i], q[0]);
      if (ctl[i][6]) begin
        pin_period();
        chk("pin_period", 8'(`RTC_TICK_HZ / 1024), 8'(n));
      end else begin
        chk("pin_level", {7'h00, !ctl[i][7]}, {7'h00, pin_oe});
      end
    end
    m.cond(1'b1, 1'b0);
    m.xfer(DW, 1'b0, b, a);
    m.xfer(8'h05, 1'b0, b, a);
    supply_ok = 1'b0;
    m.xfer(8'h33, 1'b0, b, a);
    chk("ack_off", 8'h00, {7'h00, a});
    m.cond(1'b0, 1'b1);
    wr(DW, 8'h01, {8'h44}, 1'b0);
    supply_ok = 1'b1;
    repeat (8) @(negedge clock);
    rd(1'b0, 8'h00, 2);
    chk("ptr_clear", d[1], q[0]);
    chk("no_write", d[2], q[1]);
    stop_test();
  end
endmodule // rtc_serial_clock_tb_top
`default_nettype wire
